// File: inc/led_status_pkg.sv
// Purpose: Shared constants and types for the tri-colour status indicator.
// Assumes: 50 MHz clock; flash periods are not documented, so defaults are
//          chosen to be clearly distinguishable.
// Notes:   Colour codes are {red, green}; yellow lights both.
package led_status_pkg;

  // Clock rate in hertz.
  localparam int unsigned CLK_HZ = 50000000;

  // Flash half-periods in milliseconds.
  localparam int unsigned FAST_HALF_MS   = 50;
  localparam int unsigned NORMAL_HALF_MS = 200;
  localparam int unsigned SLOW_HALF_MS   = 500;

  // Half-period counts in cycles, derived from the rate.
  localparam int unsigned FAST_HALF_CYC   = CLK_HZ / 1000 * FAST_HALF_MS;
  localparam int unsigned NORMAL_HALF_CYC = CLK_HZ / 1000 * NORMAL_HALF_MS;
  localparam int unsigned SLOW_HALF_CYC   = CLK_HZ / 1000 * SLOW_HALF_MS;

  // Power-up sequence phase length in seconds and cycles.
  localparam int unsigned STARTUP_PHASE_S   = 10;
  localparam int unsigned STARTUP_PHASE_CYC = CLK_HZ * STARTUP_PHASE_S;

  // Phase error band limits in degrees.
  localparam logic [8:0] PHASE_OK_DEG  = 9'h00a;
  localparam logic [8:0] PHASE_MAX_DEG = 9'h01e;

  // Display mode selection codes.
  localparam logic [1:0] MODE_MEASURE   = 2'h0;
  localparam logic [1:0] MODE_CLEARANCE = 2'h1;
  localparam logic [1:0] MODE_SPEED     = 2'h2;

  // Colour codes {red, green}.
  typedef enum logic [1:0] {
    COL_OFF    = 2'h0,
    COL_GREEN  = 2'h1,
    COL_RED    = 2'h2,
    COL_YELLOW = 2'h3
  } colour_t;

  // Reset value of the blink state.
  localparam logic BLINK_RESET = 1'b0;

endpackage

// File: design/flash_divider.sv
// Purpose: Square-wave flash generator from a cycle divider.
// Assumes: HALF_CYC is at least 1.
// Notes:   Counter and phase freeze while the clock enable is low.
`timescale 1ns/1ns
module flash_divider
  import led_status_pkg::*;
#(
  parameter int unsigned HALF_CYC = 10
) (
  // Clocking
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic clk_en_in,
  // Flash output
  output logic      phase_out
);

  localparam int unsigned CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          phase_reg;
  logic          phase_next;

  // Count to the half period, then toggle the phase.
  always_comb begin
    cnt_next   = cnt_reg;
    phase_next = phase_reg;
    if (cnt_reg == LAST) begin
      cnt_next   = '0;
      phase_next = ~phase_reg;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  // Register the divider state.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_reg   <= '0;
      phase_reg <= BLINK_RESET;
    end else if (clk_en_in) begin
      cnt_reg   <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  assign phase_out = phase_reg;

endmodule

// File: design/status_led_indicator.sv
// Purpose: Drives the stator tri-colour status LED in three display modes.
// Assumes: Status flags come from logic on clk_in; the two speed tracks
//          come from pins and are synchronised here.
// Notes:   Phase error is measured as track lag in cycles versus period.
// Functional notes
// - Three display modes: measuring, clearance setting, speed setting.
// - Measuring mode: fast green flash during a service data transfer.
// - Measuring mode: normal green flash while the CAN node is operational.
// - With fieldbus option, steady green during cyclic data exchange.
// - Measuring mode: slow yellow flash during rotor communication.
// - Fieldbus option: steady yellow while searching, configuring or idle.
// - Flashing red on any overflow; steady red on error.
// - Fieldbus exchange and setup indications take priority over CAN indications; idle fieldbus yellow does not.
// - Clearance mode: green good, yellow borderline, red bad alignment.
// - Speed mode: green when tracks are in quadrature, leading or lagging.
// - Speed mode: yellow when phase error is within the marginal band.
// - Speed mode: red when phase error exceeds the marginal band.
// - Clearance mode power-up: red flash, yellow flash, then steady display.
// - Flash green at the normal rate while data moves over CAN; fieldbus exchange shows steady green.
`timescale 1ns/1ns
module status_led_indicator
  import led_status_pkg::*;
#(
  parameter int unsigned FAST_CYC    = FAST_HALF_CYC,
  parameter int unsigned NORMAL_CYC  = NORMAL_HALF_CYC,
  parameter int unsigned SLOW_CYC    = SLOW_HALF_CYC,
  parameter int unsigned STARTUP_CYC = STARTUP_PHASE_CYC,
  parameter int unsigned PW          = 24
) (
  // Clocking
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       clk_en_in,
  // Mode selection
  input  wire logic [1:0] mode_sel_in,
  // Measuring mode status
  input  wire logic       sdo_active_in,
  input  wire logic       can_operational_in,
  input  wire logic       can_traffic_in,
  input  wire logic       fb_option_in,
  input  wire logic       fb_exchange_in,
  input  wire logic       fb_setup_in,
  input  wire logic       rotor_comm_in,
  input  wire logic       overflow_in,
  input  wire logic       error_in,
  // Clearance grading
  input  wire logic       align_ok_in,
  input  wire logic       align_border_in,
  // Speed track pins
  input  wire logic [1:0] speed_track_pair_in,
  // LED drive and start-up busy flag
  output logic            led_red_out,
  output logic            led_green_out,
  output logic            startup_busy_out
);

  logic fast_ph;
  logic norm_ph;
  logic slow_ph;

  // Three independent dividers keep the rates distinct.
  flash_divider #(.HALF_CYC(FAST_CYC)) u_fast (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .phase_out  (fast_ph)
  );
  flash_divider #(.HALF_CYC(NORMAL_CYC)) u_norm (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .phase_out  (norm_ph)
  );
  flash_divider #(.HALF_CYC(SLOW_CYC)) u_slow (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .phase_out  (slow_ph)
  );

  // Three-stage track synchronisers; stage one feeds only stage two.
  logic [1:0] s1_reg;
  logic [1:0] s2_reg;
  logic [1:0] s3_reg;
  logic [1:0] trk_reg;
  logic [1:0] trk_next;

  // A change counts once stages two and three agree.
  always_comb begin
    trk_next = trk_reg;
    for (int i = 0; i < 2; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        trk_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s1_reg  <= 2'h0;
      s2_reg  <= 2'h0;
      s3_reg  <= 2'h0;
      trk_reg <= 2'h0;
    end else if (clk_en_in) begin
      s1_reg  <= speed_track_pair_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      trk_reg <= trk_next;
    end
  end

  // Phase measurement: period between A rises, lag from A rise to B rise.
  logic [PW-1:0] cnt_reg, cnt_next;
  logic [PW-1:0] period_reg, period_next;
  logic [PW-1:0] lag_reg, lag_next;
  logic          a_q_reg, b_q_reg;
  logic          valid_reg, valid_next;
  wire           a_rise = trk_reg[0] & ~a_q_reg;
  wire           b_rise = trk_reg[1] & ~b_q_reg;

  always_comb begin
    cnt_next    = cnt_reg;
    period_next = period_reg;
    lag_next    = lag_reg;
    valid_next  = valid_reg;
    if (a_rise) begin
      period_next = cnt_reg;
      cnt_next    = PW'(1); // Rise cycle counts, so lag and period are exact.
      valid_next  = 1'b1;
    end else if (cnt_reg != '1) begin
      cnt_next = cnt_reg + 1'b1;
    end else begin
      valid_next = 1'b0; // Rotor stopped: no grading possible.
    end
    if (b_rise) begin
      lag_next = a_rise ? '0 : cnt_reg;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_reg    <= '0;
      period_reg <= '0;
      lag_reg    <= '0;
      a_q_reg    <= 1'b0;
      b_q_reg    <= 1'b0;
      valid_reg  <= 1'b0;
    end else if (clk_en_in) begin
      cnt_reg    <= cnt_next;
      period_reg <= period_next;
      lag_reg    <= lag_next;
      a_q_reg    <= trk_reg[0];
      b_q_reg    <= trk_reg[1];
      valid_reg  <= valid_next;
    end
  end

  // Error to nearest quadrature in scaled units: 360*lag vs 90 or 270*period.
  logic [PW+9:0] lag360, q90, q270, err1, err2, err, lim_ok, lim_max;
  colour_t       speed_col;
  always_comb begin
    lag360  = (PW+10)'(lag_reg) * (PW+10)'(360);
    q90     = (PW+10)'(period_reg) * (PW+10)'(90);
    q270    = (PW+10)'(period_reg) * (PW+10)'(270);
    err1    = (lag360 > q90) ? lag360 - q90 : q90 - lag360;
    err2    = (lag360 > q270) ? lag360 - q270 : q270 - lag360;
    err     = (err1 < err2) ? err1 : err2;
    lim_ok  = (PW+10)'(period_reg) * (PW+10)'(PHASE_OK_DEG);
    lim_max = (PW+10)'(period_reg) * (PW+10)'(PHASE_MAX_DEG);
    if (!valid_reg || err > lim_max) begin
      speed_col = COL_RED;
    end else if (err >= lim_ok) begin
      speed_col = COL_YELLOW;
    end else begin
      speed_col = COL_GREEN;
    end
  end

  // Power-up sequence in clearance mode.
  typedef enum logic [1:0] {ST_RED, ST_YELLOW, ST_DONE} start_t;
  start_t        st_reg, st_next;
  logic   [31:0] tmr_reg, tmr_next;

  always_comb begin
    st_next  = st_reg;
    tmr_next = tmr_reg + 32'h1;
    case (st_reg)
      ST_RED: begin
        if (tmr_reg == 32'(STARTUP_CYC - 1)) begin
          st_next  = ST_YELLOW;
          tmr_next = 32'h0;
        end
      end
      ST_YELLOW: begin
        if (tmr_reg == 32'(STARTUP_CYC - 1)) begin
          st_next  = ST_DONE;
          tmr_next = 32'h0;
        end
      end
      ST_DONE: tmr_next = 32'h0;
      default: st_next = ST_DONE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_reg  <= ST_RED;
      tmr_reg <= 32'h0;
    end else if (clk_en_in) begin
      st_reg  <= st_next;
      tmr_reg <= tmr_next;
    end
  end

  // Display selection per mode; fieldbus exchange and setup checked before CAN, idle fieldbus after.
  colour_t col_next;
  logic    col_red_reg, col_green_reg;
  always_comb begin
    col_next = COL_OFF;
    case (mode_sel_in)
      MODE_MEASURE: begin
        if (error_in) begin
          col_next = COL_RED;
        end else if (overflow_in) begin
          col_next = fast_ph ? COL_RED : COL_OFF;
        end else if (fb_option_in && fb_exchange_in) begin
          col_next = COL_GREEN;
        end else if (fb_option_in && fb_setup_in) begin
          col_next = COL_YELLOW;
        end else if (sdo_active_in) begin
          col_next = fast_ph ? COL_GREEN : COL_OFF;
        end else if (can_operational_in || can_traffic_in) begin
          col_next = norm_ph ? COL_GREEN : COL_OFF;
        end else if (rotor_comm_in) begin
          col_next = slow_ph ? COL_YELLOW : COL_OFF;
        end else if (fb_option_in) begin
          col_next = COL_YELLOW; // Idle fieldbus.
        end
      end
      MODE_CLEARANCE: begin
        if (st_reg == ST_RED) begin
          col_next = norm_ph ? COL_RED : COL_OFF;
        end else if (st_reg == ST_YELLOW) begin
          col_next = norm_ph ? COL_YELLOW : COL_OFF;
        end else if (align_ok_in) begin
          col_next = COL_GREEN;
        end else if (align_border_in) begin
          col_next = COL_YELLOW;
        end else begin
          col_next = COL_RED;
        end
      end
      MODE_SPEED: col_next = speed_col;
      default: col_next = COL_OFF;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      col_red_reg   <= 1'b0;
      col_green_reg <= 1'b0;
    end else if (clk_en_in) begin
      col_red_reg   <= col_next[1];
      col_green_reg <= col_next[0];
    end
  end

  assign led_red_out      = col_red_reg;
  assign led_green_out    = col_green_reg;
  assign startup_busy_out = (st_reg != ST_DONE);

  // Error always shows steady red one cycle later in measuring mode.
  a_error_red: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    clk_en_in && mode_sel_in == MODE_MEASURE && error_in |=>
    led_red_out && !led_green_out)
    else $error("error did not give steady red");

  // Fieldbus exchange beats CAN activity.
  a_fb_priority: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    clk_en_in && mode_sel_in == MODE_MEASURE && !error_in && !overflow_in
    && fb_option_in && fb_exchange_in && can_operational_in |=>
    led_green_out && !led_red_out)
    else $error("fieldbus did not take priority");

  // Clearance bad alignment after start-up shows red.
  a_clear_red: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    clk_en_in && mode_sel_in == MODE_CLEARANCE && st_reg == ST_DONE
    && !align_ok_in && !align_border_in |=> led_red_out && !led_green_out)
    else $error("bad alignment not red");

  // Start-up moves from red flash to yellow flash.
  sequence s_red_end;
    clk_en_in && st_reg == ST_RED && tmr_reg == 32'(STARTUP_CYC - 1);
  endsequence
  a_start_seq: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    s_red_end |=> st_reg == ST_YELLOW && tmr_reg == 32'h0)
    else $error("start-up sequence step wrong");

  // Stopped rotor grades red in speed mode.
  a_speed_stop: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    clk_en_in && mode_sel_in == MODE_SPEED && !valid_reg |=> led_red_out)
    else $error("stopped rotor not red");

  // Operational CAN alone gives green only in the normal-rate phase.
  a_can_flash: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    clk_en_in && mode_sel_in == MODE_MEASURE && !error_in && !overflow_in
    && !fb_option_in && !sdo_active_in && can_operational_in |=>
    led_green_out == $past(norm_ph) && !led_red_out)
    else $error("CAN flash wrong");

  // Rotor link alone flashes yellow at the slow rate.
  a_rotor_flash: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    clk_en_in && mode_sel_in == MODE_MEASURE && !error_in && !overflow_in
    && !fb_option_in && !sdo_active_in && !can_operational_in
    && !can_traffic_in && rotor_comm_in |=>
    led_red_out == $past(slow_ph) && led_green_out == $past(slow_ph))
    else $error("rotor flash wrong");

  // Service data transfer uses the fast rate.
  a_sdo_flash: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    clk_en_in && mode_sel_in == MODE_MEASURE && !error_in && !overflow_in
    && !fb_option_in && sdo_active_in |=>
    led_green_out == $past(fast_ph) && !led_red_out)
    else $error("SDO flash wrong");

endmodule

// File: sim/track_source.sv
// Purpose: Two-track optical speed source feeding the speed setting display.
// Assumes: Period is even, at least 4 cycles, and the lag is below it.
// Notes:   Both lines sit low while stopped, so the block sees no edge.
`timescale 1ns/1ns
module track_source (
  // Clocking
  input  wire logic       clk_in,
  // Waveform control
  input  wire logic       run_in,
  input  wire logic [7:0] period_in,
  input  wire logic [7:0] lag_in,
  // Track pins
  output logic      [1:0] track_out
);
  logic [7:0] pos_reg;
  logic [7:0] rel;

  // Position within one slot period, restarted whenever the disc stops.
  always_ff @(posedge clk_in) begin
    if (!run_in || pos_reg >= period_in - 8'h01) begin
      pos_reg <= 8'h00;
    end else begin
      pos_reg <= pos_reg + 8'h01;
    end
  end

  // Track B rises lag cycles after track A, both at half duty.
  always_comb begin
    rel = (pos_reg >= lag_in) ? pos_reg - lag_in
                              : pos_reg + period_in - lag_in;
    track_out[0] = run_in && (pos_reg < (period_in >> 1));
    track_out[1] = run_in && (rel < (period_in >> 1));
  end
endmodule

// File: sim/status_led_indicator_tb.sv
// Purpose: Self-checking bench for the tri-colour status indicator.
// Assumes: Shortened divider and start-up counts set below.
// Notes:   Flash rates are judged by toggle counts over a fixed window.
`timescale 1ns/1ns
module status_led_indicator_tb;
  import led_status_pkg::*;

  // Short counts keep the whole run brief.
  localparam int unsigned FAST  = 2;
  localparam int unsigned NORM  = 4;
  localparam int unsigned SLOW  = 8;
  localparam int unsigned START = 20;

  // Stimulus; flags are {sdo,canop,traffic,fbopt,exch,setup,rotor,ovf,err}.
  logic       clk_in          = 1'b0;
  logic       sys_rst_in      = 1'b1;
  logic       clk_en_in       = 1'b1;
  logic [1:0] mode_sel_in     = MODE_CLEARANCE;
  logic [8:0] flags           = 9'h000;
  logic       align_ok_in     = 1'b1;
  logic       align_border_in = 1'b0;
  logic       run             = 1'b0;
  logic [7:0] lag             = 8'h12;
  logic [1:0] tracks;
  logic       led_red_out;
  logic       led_green_out;
  logic       startup_busy_out;
  int         err_total       = 0;
  int         compares        = 0;

  // Free-running 50 MHz clock.
  always #10 clk_in = ~clk_in;

  status_led_indicator #(.FAST_CYC(FAST), .NORMAL_CYC(NORM),
    .SLOW_CYC(SLOW), .STARTUP_CYC(START), .PW(8)) DUT (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .mode_sel_in(mode_sel_in), .sdo_active_in(flags[8]),
    .can_operational_in(flags[7]), .can_traffic_in(flags[6]),
    .fb_option_in(flags[5]), .fb_exchange_in(flags[4]),
    .fb_setup_in(flags[3]), .rotor_comm_in(flags[2]),
    .overflow_in(flags[1]), .error_in(flags[0]),
    .align_ok_in(align_ok_in), .align_border_in(align_border_in),
    .speed_track_pair_in(tracks), .led_red_out(led_red_out),
    .led_green_out(led_green_out), .startup_busy_out(startup_busy_out));

  // The disc period is 72 cycles, so one cycle of lag is 5 degrees.
  track_source src (.clk_in(clk_in), .run_in(run), .period_in(8'h48),
    .lag_in(lag), .track_out(tracks));

  task automatic report_and_stop();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Counts lit cycles, toggles and red/green disagreement at falling edges.
  task automatic observe(input int n, output int rh, gh, rt, gt, df);
    logic pr;
    logic pg;
    rh = 0;
    gh = 0;
    rt = 0;
    gt = 0;
    df = 0;
    @(negedge clk_in);
    pr = led_red_out;
    pg = led_green_out;
    repeat (n) begin
      @(negedge clk_in);
      rh += (led_red_out === 1'b1);
      gh += (led_green_out === 1'b1);
      rt += (led_red_out !== pr);
      gt += (led_green_out !== pg);
      df += (led_red_out !== led_green_out);
      pr = led_red_out;
      pg = led_green_out;
    end
  endtask

  // Half period h of zero means steady; a window holds 32/h toggles.
  task automatic expect_led(input string what, input colour_t c, input int h);
    int   rh, gh, rt, gt, df, lo, hi;
    logic rok, gok;
    observe(32, rh, gh, rt, gt, df);
    lo  = (h == 0) ? 0 : 32 / h - 1;
    hi  = (h == 0) ? 0 : 32 / h + 1;
    rok = (h == 0) ? (rh == 32) : (rt >= lo && rt <= hi);
    gok = (h == 0) ? (gh == 32) : (gt >= lo && gt <= hi);
    check({what, " red"}, 1, c[1] ? rok : rh == 0);
    check({what, " green"}, 1, c[0] ? gok : gh == 0);
    if (c == COL_YELLOW) check({what, " pair"}, 0, df);
  endtask

  task automatic test_startup();
    int rh, gh, rt, gt, df, k;
    @(negedge clk_in);
    check("busy at start", 1, startup_busy_out);
    observe(16, rh, gh, rt, gt, df);
    check("start red flash", 1, rt >= 3);
    check("start red only", 0, gh);
    repeat (4) @(negedge clk_in);
    observe(16, rh, gh, rt, gt, df);
    check("start yellow flash", 1, rt >= 3);
    check("start yellow pair", 0, df);
    k = 0;
    while (startup_busy_out !== 1'b0 && k < 60) begin
      @(negedge clk_in);
      k++;
    end
    if (k == 60) begin
      check("start timeout", 0, 1);
      report_and_stop();
    end
    expect_led("start settle", COL_GREEN, 0);
    $display("test startup done");
  endtask

  task automatic clr_case(input string what, input logic ok, input logic bd,
                          input colour_t c);
    @(posedge clk_in);
    align_ok_in     <= ok;
    align_border_in <= bd;
    repeat (3) @(posedge clk_in);
    expect_led(what, c, 0);
  endtask

  task automatic test_clearance();
    clr_case("clr ok", 1'b1, 1'b0, COL_GREEN);
    clr_case("clr border", 1'b0, 1'b1, COL_YELLOW);
    clr_case("clr bad", 1'b0, 1'b0, COL_RED);
    $display("test clearance done");
  endtask

  task automatic meas_case(input string what, input logic [8:0] f,
                           input colour_t c, input int h);
    @(posedge clk_in);
    mode_sel_in <= MODE_MEASURE;
    flags       <= f;
    repeat (3) @(posedge clk_in);
    expect_led(what, c, h);
  endtask

  task automatic test_measure();
    meas_case("m error", 9'h003, COL_RED, 0);
    meas_case("m overflow", 9'h102, COL_RED, FAST);
    meas_case("m fb exch", 9'h0b0, COL_GREEN, 0);
    meas_case("m fb setup", 9'h128, COL_YELLOW, 0);
    meas_case("m sdo", 9'h180, COL_GREEN, FAST);
    meas_case("m can op", 9'h080, COL_GREEN, NORM);
    meas_case("m traffic", 9'h040, COL_GREEN, NORM);
    meas_case("m rotor", 9'h004, COL_YELLOW, SLOW);
    meas_case("m fb idle", 9'h020, COL_YELLOW, 0);
    meas_case("m no option", 9'h018, COL_OFF, 0);
    meas_case("m none", 9'h000, COL_OFF, 0);
    @(posedge clk_in);
    mode_sel_in <= 2'h3;
    flags       <= 9'h001;
    repeat (3) @(posedge clk_in);
    expect_led("m dark", COL_OFF, 0);
    $display("test measure done");
  endtask

  task automatic spd_case(input string what, input logic [7:0] l,
                          input logic r, input colour_t c);
    @(posedge clk_in);
    mode_sel_in <= MODE_SPEED;
    lag         <= l;
    run         <= r;
    repeat (300) @(posedge clk_in);
    expect_led(what, c, 0);
  endtask

  task automatic test_speed();
    spd_case("s lead", 8'h12, 1'b1, COL_GREEN);
    spd_case("s lag", 8'h36, 1'b1, COL_GREEN);
    spd_case("s err 20", 8'h16, 1'b1, COL_YELLOW);
    spd_case("s err 20 low", 8'h0e, 1'b1, COL_YELLOW);
    spd_case("s err 10", 8'h14, 1'b1, COL_YELLOW);
    spd_case("s err 30", 8'h18, 1'b1, COL_YELLOW);
    spd_case("s err 35", 8'h19, 1'b1, COL_RED);
    spd_case("s err 90", 8'h24, 1'b1, COL_RED);
    spd_case("s stopped", 8'h12, 1'b0, COL_RED);
    $display("test speed done");
  endtask

  // A low enable must freeze the flash dividers entirely.
  task automatic test_freeze();
    int rh, gh, rt, gt, df;
    meas_case("f run", 9'h080, COL_GREEN, NORM);
    @(posedge clk_in);
    clk_en_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    observe(20, rh, gh, rt, gt, df);
    check("frozen toggles", 0, rt + gt);
    @(posedge clk_in);
    clk_en_in <= 1'b1;
    $display("test freeze done");
  endtask

  // Main sequence: reset for five cycles, then each scenario in turn.
  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    test_startup();
    test_clearance();
    test_measure();
    test_speed();
    test_freeze();
    report_and_stop();
  end
endmodule
